// ==== logic/odf_device.sv ====
`timescale 1ns/1ps
// How it works
// R1 - sixteen bit word, channel eight highest
// R2 - codes: none, open, short, overcurrent
// R3 - all ones means thermal fault
// R4 - first variant clears all on valid word
// R5 - second variant clears overcurrent on restart-time expiry/input low
// R6 - overcurrent overwrites, later faults ignored
// R7 - overcurrent only when on and switch-off
// R8 - no-latch samples off state at cs fall
// R9 - open load between thresholds, channel off
// R10 - short below low threshold when low-side, above high threshold when high-side
// R11 - latch mode holds filtered faults
// R12 - filtered overcurrent trips output, writes code
// R13 - restart after restart time
// R14 - host off-then-on restarts output
// R15 - direct input rising edge restarts channels 6-8
// R16 - host filters 6-8 after input fall
// R17 - host filters long turn-off transients
// R18 - diag mode kept per channel
// R19 - diag 1 latch, protect 1 linear
// R20 - reset: off, no-latch, switch-off, cleared
// R21 - thermal at cs fall loads all ones
// R22 - parameter selects overcurrent clear style
module odf_device
  import odf_pkg::*;
#(
  parameter bit OVC_CLEAR_ON_RESTART = 1'b0 // [R22]
)(
  input  wire logic         clk_sys,          // system clock
  input  wire logic         reset,            // async reset
  odf_link_if.dev           link,             // serial link
  input  wire logic [7:0]   belowLow,         // output under ground-side threshold
  input  wire logic [7:0]   aboveHigh,        // output over battery-side threshold
  input  wire logic [7:0]   highSide,         // channel is high-side configured
  input  wire logic [7:0]   overCurrent,      // current above trip level
  input  wire logic [7:0]   thermal,          // thermal shutdown active
  input  wire logic [2:0]   direct_drive_input, // channels 6-8 parallel inputs
  output logic [7:0]        driveOn,          // output switch enables
  output logic [15:0]       channel_fault_status // fault word
);
  ////////////////////////////////////////////////////////////////////////
  logic [2:0] sckS, csS, dinS;
  logic [2:0] dirS1, dirS2, dirPrev;
  always_ff @(posedge clk_sys or posedge reset)
    if (reset)
    begin
      sckS <= '0; csS <= 3'h7; dinS <= '0;
      dirS1 <= '0; dirS2 <= '0; dirPrev <= '0;
    end
    else
    begin
      sckS <= {sckS[1:0], link.sclk};
      csS  <= {csS[1:0], link.csN};
      dinS <= {dinS[1:0], link.serialIn};
      dirS1 <= direct_drive_input;
      dirS2 <= dirS1;
      dirPrev <= dirS2;
    end
  // comparator and thermal levels arrive asynchronously
  logic [7:0] lowS1, lowS2, highS1, highS2, sideS1, sideS2;
  logic [7:0] ocS1, ocS2, hotS1, hotS2;
  always_ff @(posedge clk_sys or posedge reset)
    if (reset)
    begin
      lowS1  <= '0;
      lowS2  <= '0;
      highS1 <= '0;
      highS2 <= '0;
      sideS1 <= '0;
      sideS2 <= '0;
      ocS1   <= '0;
      ocS2   <= '0;
      hotS1  <= '0;
      hotS2  <= '0;
    end
    else
    begin
      lowS1  <= belowLow;
      lowS2  <= lowS1;
      highS1 <= aboveHigh;
      highS2 <= highS1;
      sideS1 <= highSide;
      sideS2 <= sideS1;
      ocS1   <= overCurrent;
      ocS2   <= ocS1;
      hotS1  <= thermal;
      hotS2  <= hotS1;
    end
  wire sckRise = sckS[1] & ~sckS[2];
  wire sckFall = ~sckS[1] & sckS[2];
  wire csFall  = ~csS[1] & csS[2];
  wire csRise  = csS[1] & ~csS[2];
  wire active  = ~csS[1];
  wire [7:0] dirRise = {(dirS2 & ~dirPrev), 5'h00};
  wire [7:0] dirLow  = {~dirS2, 5'h00};
  ////////////////////////////////////////////////////////////////////////
  logic [15:0] rxShift_reg, txShift_reg;
  logic [4:0]  bitCnt_reg;
  logic        sout_reg;
  always_ff @(posedge clk_sys or posedge reset)
    if (reset)
    begin
      rxShift_reg <= '0; bitCnt_reg <= '0;
    end
    else if (csFall)
      bitCnt_reg <= '0;
    else if (active && sckRise)
    begin
      rxShift_reg <= {rxShift_reg[14:0], dinS[1]};
      if (bitCnt_reg != 5'h10)
        bitCnt_reg <= bitCnt_reg + 5'h01;
    end
  wire validEnd = csRise && (bitCnt_reg == 5'h10);
  wire [3:0] wKey = rxShift_reg[15:12];
  wire [3:0] wMode = rxShift_reg[11:8];
  wire [7:0] wData = rxShift_reg[7:0];
  ////////////////////////////////////////////////////////////////////////
  logic [7:0] cmdOn_reg, latchMode_reg, linear_reg, prevOn_reg;
  logic [7:0] hostRestart;
  always_comb
  begin
    hostRestart = '0;
    if (validEnd && wKey == KEY_NIB && wMode == MODE_OUTPUT)
      hostRestart = wData & ~prevOn_reg; // [R14]
  end
  always_ff @(posedge clk_sys or posedge reset)
    if (reset)
    begin
      cmdOn_reg <= '0; latchMode_reg <= '0; linear_reg <= '0; prevOn_reg <= '0; // [R20]
    end
    else if (validEnd && wKey == KEY_NIB)
    begin
      case (wMode)
        MODE_OUTPUT:
        begin
          cmdOn_reg <= wData;
          prevOn_reg <= wData;
        end
        MODE_DIAG:    latchMode_reg <= wData; // [R18] [R19]
        MODE_PROTECT: linear_reg <= wData; // [R19]
        default:      ;
      endcase
    end
  ////////////////////////////////////////////////////////////////////////
  logic [15:0] fault_reg;
  logic [7:0]  tripped_reg;
  logic [CNT_W-1:0] filtCnt [NCH];
  logic [CNT_W-1:0] ovcCnt  [NCH];
  logic [CNT_W-1:0] resCnt  [NCH];
  logic [7:0] openNow, shortNow, openQual, shortQual, ovcTrip, resDone, restart;
  genvar i;
  generate
    for (i = 0; i < NCH; i++)
    begin : g_ch
      wire off = ~cmdOn_reg[i] | tripped_reg[i];
      assign openNow[i]  = off & ~lowS2[i] & ~highS2[i]; // [R9]
      assign shortNow[i] = off & (sideS2[i] ? highS2[i] : lowS2[i]); // [R10]
      assign ovcTrip[i]  = (ovcCnt[i] == CNT_W'(DEL_CYC)); // [R12]
      assign resDone[i]  = tripped_reg[i] && (resCnt[i] == CNT_W'(RES_CYC)); // [R13]
      assign openQual[i]  = openNow[i] && (filtCnt[i] == CNT_W'(FILT_CYC)); // [R11]
      assign shortQual[i] = shortNow[i] && (filtCnt[i] == CNT_W'(FILT_CYC));
      assign restart[i]  = resDone[i] | hostRestart[i] | dirRise[i]; // [R15]
      always_ff @(posedge clk_sys or posedge reset)
        if (reset)
        begin
          filtCnt[i] <= '0; ovcCnt[i] <= '0; resCnt[i] <= '0; tripped_reg[i] <= 1'b0;
        end
        else
        begin
          if (!(openNow[i] || shortNow[i]))
            filtCnt[i] <= '0;
          else if (filtCnt[i] != CNT_W'(FILT_CYC))
            filtCnt[i] <= filtCnt[i] + CNT_W'(1);
          if (!(cmdOn_reg[i] && !tripped_reg[i] && !linear_reg[i] && ocS2[i])) // [R7]
            ovcCnt[i] <= '0;
          else if (!ovcTrip[i])
            ovcCnt[i] <= ovcCnt[i] + CNT_W'(1);
          // a trip beats a restart in the same cycle
          if (ovcTrip[i] && cmdOn_reg[i] && !tripped_reg[i])
            tripped_reg[i] <= 1'b1; // [R12]
          else if (restart[i] || !cmdOn_reg[i])
            tripped_reg[i] <= 1'b0;
          if (!tripped_reg[i])
            resCnt[i] <= '0;
          else if (!resDone[i])
            resCnt[i] <= resCnt[i] + CNT_W'(1);
        end
      assign driveOn[i] = cmdOn_reg[i] & ~tripped_reg[i];
    end
  endgenerate
  ////////////////////////////////////////////////////////////////////////
  logic [15:0] fnext;
  always_comb
  begin
    fnext = fault_reg;
    if (validEnd)
    begin
      for (int c = 0; c < NCH; c++)
        if (!OVC_CLEAR_ON_RESTART || fnext[2*c +: 2] != CODE_OVC || fault_reg == THERMAL_WORD)
          fnext[2*c +: 2] = CODE_NONE; // [R4] [R5]
    end
    for (int c = 0; c < NCH; c++)
    begin
      if (OVC_CLEAR_ON_RESTART && fnext[2*c +: 2] == CODE_OVC && fault_reg != THERMAL_WORD
          && (resDone[c] || dirLow[c]))
        fnext[2*c +: 2] = CODE_NONE; // [R5]
      if (ovcTrip[c] && cmdOn_reg[c] && !tripped_reg[c])
        fnext[2*c +: 2] = CODE_OVC; // [R6] [R12]
      else if (fnext[2*c +: 2] != CODE_OVC && latchMode_reg[c])
      begin
        if (shortQual[c])
          fnext[2*c +: 2] = CODE_SHORT; // [R2] [R11]
        else if (openQual[c] && fnext[2*c +: 2] == CODE_NONE)
          fnext[2*c +: 2] = CODE_OPEN;
      end
      else if (csFall && fnext[2*c +: 2] != CODE_OVC && !latchMode_reg[c])
        fnext[2*c +: 2] = shortNow[c] ? CODE_SHORT : (openNow[c] ? CODE_OPEN : CODE_NONE); // [R8]
    end
    if (csFall && |hotS2)
      fnext = THERMAL_WORD; // [R21] [R3]
  end
  always_ff @(posedge clk_sys or posedge reset)
    if (reset)
      fault_reg <= FAULT_RESET; // [R20]
    else
      fault_reg <= fnext;
  assign channel_fault_status = fault_reg; // [R1]
  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys or posedge reset)
    if (reset)
    begin
      txShift_reg <= '0; sout_reg <= 1'b0;
    end
    else if (csFall)
    begin
      txShift_reg <= {fnext[14:0], 1'b0};
      sout_reg <= fnext[15];
    end
    else if (active && sckFall)
    begin
      sout_reg <= txShift_reg[15];
      txShift_reg <= {txShift_reg[14:0], rxShift_reg[15]};
    end
  assign link.serialOut = sout_reg;
endmodule : odf_device

// ==== logic/odf_host.sv ====
`timescale 1ns/1ps
module odf_host
  import odf_pkg::*;
(
  input  wire logic        clk_sys,     // system clock
  input  wire logic        reset,       // async reset
  odf_link_if.host         link,        // serial link
  input  wire logic        start,       // begin a transfer
  input  wire logic [15:0] txWord,      // command word to send
  output logic             busy,        // transfer running
  output logic             done,        // one-cycle end pulse
  output logic [15:0]      rxWord,      // fault word received
  output logic             thermalSeen  // received word was all ones
);
  typedef enum logic [1:0] {IDLE = 2'h0, LEAD = 2'h1, SHIFT = 2'h3, TRAIL = 2'h2} odf_hst_t;
  odf_hst_t st_reg;
  logic [5:0]  div_reg;
  logic [4:0]  cnt_reg;
  logic [15:0] tx_reg, rx_reg;
  logic        sck_reg, cs_reg, soS1, soS2;
  wire tick = (div_reg == DIV_W);
  always_ff @(posedge clk_sys or posedge reset)
    if (reset)
    begin
      soS1 <= 1'b0; soS2 <= 1'b0;
    end
    else
    begin
      soS1 <= link.serialOut;
      soS2 <= soS1;
    end
  always_ff @(posedge clk_sys or posedge reset)
    if (reset)
      div_reg <= '0;
    else
      div_reg <= tick ? 6'h00 : div_reg + 6'h01;
  always_ff @(posedge clk_sys or posedge reset)
    if (reset)
    begin
      st_reg <= IDLE; sck_reg <= 1'b0; cs_reg <= 1'b1; cnt_reg <= '0;
      tx_reg <= '0; rx_reg <= '0; rxWord <= '0; done <= 1'b0; thermalSeen <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      case (st_reg)
        IDLE:
          if (start)
          begin
            tx_reg <= txWord; cs_reg <= 1'b0; cnt_reg <= '0; st_reg <= LEAD;
          end
        LEAD:
          if (tick)
            st_reg <= SHIFT;
        SHIFT:
          if (tick)
          begin
            sck_reg <= ~sck_reg;
            // sample at clock fall, before the delayed device shift lands
            if (sck_reg)
            begin
              rx_reg <= {rx_reg[14:0], soS2};
              tx_reg <= {tx_reg[14:0], 1'b0};
              cnt_reg <= cnt_reg + 5'h01;
              if (cnt_reg == 5'h0f)
                st_reg <= TRAIL;
            end
          end
        TRAIL:
          if (tick)
          begin
            cs_reg <= 1'b1; rxWord <= rx_reg; done <= 1'b1;
            thermalSeen <= (rx_reg == THERMAL_WORD); // [R3]
            st_reg <= IDLE;
          end
        default: st_reg <= IDLE;
      endcase
    end
  assign busy = (st_reg != IDLE);
  assign link.sclk = sck_reg;
  assign link.csN = cs_reg;
  assign link.serialIn = tx_reg[15];
endmodule : odf_host

// ==== logic/odf_link_if.sv ====
`timescale 1ns/1ps
interface odf_link_if;
  logic sclk;
  logic csN;
  logic serialIn;
  logic serialOut;
  modport dev  (input sclk, input csN, input serialIn, output serialOut);
  modport host (output sclk, output csN, output serialIn, input serialOut);
endinterface : odf_link_if

// ==== logic/odf_pkg.sv ====
package odf_pkg;
  localparam int NCH           = 8;
  localparam int WORD_BITS     = 16;
  localparam int CODE_W        = 2;
  localparam logic [1:0] CODE_NONE = 2'h0;
  localparam logic [1:0] CODE_OPEN = 2'h1;
  localparam logic [1:0] CODE_SHORT = 2'h2;
  localparam logic [1:0] CODE_OVC  = 2'h3;
  localparam logic [15:0] FAULT_RESET   = 16'h0000;
  localparam logic [15:0] THERMAL_WORD  = 16'hffff;
  localparam logic [7:0]  KEY_WORD      = 8'ha0;
  localparam logic [3:0]  KEY_NIB       = 4'ha;
  localparam logic [3:0]  MODE_OUTPUT   = 4'hc;
  localparam logic [3:0]  MODE_DIAG     = 4'h3;
  localparam logic [3:0]  MODE_PROTECT  = 4'h2;
  localparam int FIRST_DIRECT   = 5;
  localparam int CLK_MHZ        = 100;
  localparam int FILT_US        = 10;
  localparam int DEL_US         = 5;
  localparam int RES_US         = 100;
  localparam int FILT_CYC       = FILT_US * CLK_MHZ;
  localparam int DEL_CYC        = DEL_US * CLK_MHZ;
  localparam int RES_CYC        = RES_US * CLK_MHZ;
  localparam int CNT_W          = 16;
  localparam int SCK_DIV        = 4;
  localparam logic [5:0] DIV_W  = 6'h04;
endpackage : odf_pkg

// ==== verification/odf_link_monitor.sv ====
`timescale 1ns/1ps
module odf_link_monitor (
  input wire logic clk_sys,  // system clock
  input wire logic reset,    // async reset
  input wire logic sclk,     // serial clock
  input wire logic csN,      // chip select, low active
  input wire logic serialIn, // command bits
  input wire logic serialOut // fault bits
);
  logic       sclkQ_reg;
  logic [4:0] nRise_reg;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset) sclkQ_reg <= 1'b0;
    else sclkQ_reg <= sclk;
  end

  // serial clock rises within the current frame
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset) nRise_reg <= 5'h00;
    else if (csN) nRise_reg <= 5'h00;
    else if (sclk && !sclkQ_reg) nRise_reg <= nRise_reg + 5'h01;
  end

  ////////////////////////////////////////////////////////////////////////////
  a_frame_sixteen: assert property ($rose(csN) |-> nRise_reg == 5'h10)
    else $error("frame without sixteen clock rises");
  a_idle_clock_low: assert property (csN |-> !sclk)
    else $error("serial clock active outside frame");
  a_select_quiet: assert property ($fell(csN) |-> !sclk [*4])
    else $error("clock too soon after select");
  a_first_edge: assert property ($fell(csN) |-> ##[2:20] $rose(sclk))
    else $error("no clock after select");
  a_clock_pulse: assert property ($rose(sclk) |-> ##[2:9] $fell(sclk))
    else $error("serial clock high too long");
  a_in_steady: assert property (sclk && $past(sclk) |-> $stable(serialIn))
    else $error("command bit moved while clock high");
  a_out_steady: assert property (sclk && $past(sclk) |-> $stable(serialOut))
    else $error("fault bit moved while clock high");
  a_frame_length: assert property ($fell(csN) |-> ##[160:400] $rose(csN))
    else $error("frame length out of range");
endmodule : odf_link_monitor

// ==== verification/tb_octal_driver_fault_diagnosis.sv ====
`timescale 1ns/1ps
module tb_octal_driver_fault_diagnosis
  import odf_pkg::*;
;
  logic        clk_sys = 1'b0;
  logic        reset = 1'b1;
  logic        start = 1'b0;
  logic [15:0] txWord = 16'h0000;
  logic [7:0]  belowLow = 8'h00;
  logic [7:0]  aboveHigh = 8'hff;
  logic [7:0]  highSide = 8'h00;
  logic [7:0]  overCurrent = 8'h00;
  logic [7:0]  thermal = 8'h00;
  logic [2:0]  directDrive = 3'h0;
  logic        done, thermalSeen, busy;
  logic [15:0] rxWord, faultWord, faultWord2;
  logic [7:0]  driveOn;
  int          n_fail = 0;
  int          checked = 0;

  odf_link_if link();
  odf_link_if link2();
  // second variant listens to the same frames
  assign link2.sclk = link.sclk;
  assign link2.csN = link.csN;
  assign link2.serialIn = link.serialIn;
  odf_device #(.OVC_CLEAR_ON_RESTART(1'b1)) i_odf_device_2 (.clk_sys, .reset, .link(link2),
    .belowLow, .aboveHigh, .highSide, .overCurrent, .thermal,
    .direct_drive_input(directDrive), .driveOn(), .channel_fault_status(faultWord2));
  odf_device i_odf_device (.clk_sys, .reset, .link(link), .belowLow, .aboveHigh, .highSide,
    .overCurrent, .thermal, .direct_drive_input(directDrive), .driveOn,
    .channel_fault_status(faultWord));
  odf_host i_odf_host (.clk_sys, .reset, .link(link), .start, .txWord, .busy, .done,
    .rxWord, .thermalSeen);
  odf_link_monitor i_odf_link_monitor (.clk_sys, .reset, .sclk(link.sclk), .csN(link.csN),
    .serialIn(link.serialIn), .serialOut(link.serialOut));

  always #5 clk_sys = ~clk_sys;

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e)
    begin
      $display("unexpected %s expected %h seen %h", s, e, g);
      n_fail++;
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : cyc

  function automatic logic [15:0] cmd(input logic [3:0] m, input logic [7:0] b);
    return {KEY_NIB, m, b};
  endfunction : cmd

  task automatic xfer(input logic [15:0] w);
    int i;
    cyc(1);
    start = 1'b1;
    txWord = w;
    cyc(1);
    start = 1'b0;
    chk("busy", 16'h0001, {15'h0000, busy});
    for (i = 0; i < 500 && done !== 1'b1; i++) cyc(1);
    if (i >= 500) chk("done", 16'h0001, 16'h0000);
    // command lands a few cycles after select rises
    cyc(4);
  endtask : xfer

  task automatic results;
    $display("checks %0d errors %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : results

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_nolatch;
    highSide = 8'h80;
    aboveHigh = 8'hfc;
    belowLow = 8'h01;
    xfer(cmd(MODE_OUTPUT, 8'h00));
    chk("codes", 16'h8006, rxWord);
    cyc(FILT_CYC + 100);
    {highSide, aboveHigh, belowLow} = {8'h00, 8'hff, 8'h00};
    xfer(cmd(MODE_OUTPUT, 8'h00));
    chk("unlatched", 16'h0000, rxWord);
  endtask : t_nolatch

  task automatic t_latch;
    xfer(cmd(MODE_DIAG, 8'h02));
    aboveHigh = 8'hfd;
    cyc(FILT_CYC / 2);
    aboveHigh = 8'hfc;
    belowLow = 8'h01;
    xfer(cmd(MODE_DIAG, 8'h02));
    chk("brief", 16'h0002, rxWord);
    cyc(FILT_CYC + 100);
    {aboveHigh, belowLow} = {8'hff, 8'h00};
    xfer(cmd(MODE_DIAG, 8'h02));
    chk("latched", 16'h0004, rxWord);
    xfer(cmd(MODE_DIAG, 8'h00));
    chk("cleared", 16'h0000, rxWord);
  endtask : t_latch

  task automatic t_trip;
    xfer(cmd(MODE_OUTPUT, 8'h01));
    chk("on", 16'h0001, {8'h00, driveOn});
    overCurrent = 8'h01;
    cyc(DEL_CYC + 50);
    chk("tripped", 16'h0000, {8'h00, driveOn});
    overCurrent = 8'h00;
    aboveHigh = 8'hfe;
    xfer(cmd(MODE_OUTPUT, 8'h01));
    chk("ovc code", 16'h0003, rxWord);
    chk("all cleared", 16'h0000, faultWord);
    chk("ovc kept", 16'h0003, faultWord2);
    aboveHigh = 8'hff;
    cyc(RES_CYC);
    chk("auto", 16'h0001, {8'h00, driveOn});
    chk("ovc expired", 16'h0000, faultWord2);
    overCurrent = 8'h01;
    cyc(DEL_CYC + 50);
    overCurrent = 8'h00;
    xfer(cmd(MODE_OUTPUT, 8'h00));
    xfer(cmd(MODE_OUTPUT, 8'h01));
    cyc(5);
    chk("host", 16'h0001, {8'h00, driveOn});
  endtask : t_trip

  task automatic t_linear;
    xfer(cmd(MODE_PROTECT, 8'h01));
    overCurrent = 8'h01;
    cyc(DEL_CYC + 50);
    chk("limit", 16'h0001, {8'h00, driveOn});
    overCurrent = 8'h00;
    xfer(cmd(MODE_PROTECT, 8'h00));
    chk("no code", 16'h0000, rxWord);
  endtask : t_linear

  task automatic t_direct;
    xfer(cmd(MODE_OUTPUT, 8'h20));
    overCurrent = 8'h20;
    cyc(DEL_CYC + 50);
    chk("trip6", 16'h0000, {8'h00, driveOn});
    overCurrent = 8'h00;
    directDrive = 3'h1;
    cyc(8);
    chk("direct", 16'h0020, {8'h00, driveOn});
    directDrive = 3'h0;
    // let the output transient settle before the next reading
    cyc(100);
  endtask : t_direct

  task automatic t_thermal;
    thermal = 8'h10;
    xfer(cmd(MODE_OUTPUT, 8'h00));
    chk("hot", THERMAL_WORD, rxWord);
    chk("seen", 16'h0001, {15'h0000, thermalSeen});
    thermal = 8'h00;
    xfer(cmd(MODE_OUTPUT, 8'h00));
    chk("cool", 16'h0000, rxWord);
  endtask : t_thermal

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    cyc(16);
    reset = 1'b0;
    chk("reset drive", 16'h0000, {8'h00, driveOn});
    chk("reset fault", FAULT_RESET, faultWord);
    t_nolatch();
    t_latch();
    t_trip();
    t_linear();
    t_direct();
    t_thermal();
    results();
  end

  initial
  begin
    #400000;
    n_fail++;
    results();
  end
endmodule : tb_octal_driver_fault_diagnosis
